// *** hw/mia_consts.svh ***
// Constants of the maskable interrupt acknowledge block.
// Assumes an 8-bit register port and a 16-bit program counter.
`ifndef MIA_CONSTS_SVH
`define MIA_CONSTS_SVH

// ****************************************
// Register offsets
// ****************************************
`define MIA_A_REQ_LO 8'h00
`define MIA_A_REQ_HI 8'h01
`define MIA_A_MSK_LO 8'h04
`define MIA_A_MSK_HI 8'h05
`define MIA_A_PSW 8'h08
`define MIA_A_IST 8'h0C
`define MIA_A_IMSK 8'h0D

// ****************************************
// Reset values and fields
// ****************************************
`define MIA_PSW_RST 8'h02
`define MIA_REQ_RST 16'h0000
`define MIA_MSK_RST 16'hFFFF
`define MIA_IST_RST 2'h0
`define MIA_IMSK_RST 2'h0
`define MIA_GEN_BIT 7
`define MIA_UNUSED_BITS 16'h8001
`define MIA_VEC_BASE 16'h0004
`define MIA_EV_ACK 0
`define MIA_EV_RET 1
`define MIA_ZERO8 8'h00
`define MIA_ZERO16 16'h0000

`endif

// *** hw/mia_pkg.sv ***
// Types of the maskable interrupt acknowledge block.
// Assumes mia_consts.svh for all numeric constants.
package mia_pkg;

	// ****************************************
	// Carriers
	// ****************************************
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} mia_bus_req_t;

	typedef struct packed {
		logic instr_penult;
		logic instr_done;
		logic en_ins;
		logic dis_ins;
		logic ret_ins;
		logic [7:0] ret_word;
		logic [15:0] pc;
	} mia_seq_in_t;

	typedef struct packed {
		logic busy;
		logic stk_push;
		logic [7:0] stk_data;
		logic pc_load;
		logic [15:0] pc_vec;
	} mia_seq_out_t;

	// Gray coded along the acknowledge path
	typedef enum logic [1:0] {
		MIA_ST_IDLE = 2'b00,
		MIA_ST_PCH = 2'b01,
		MIA_ST_PCL = 2'b11,
		MIA_ST_VEC = 2'b10
	} mia_state_t;

	typedef struct packed {
		mia_state_t st;
		logic [15:0] req;
		logic [15:0] msk;
		logic [7:0] program_status_word;
		logic [15:0] snap;
		logic acc_seen;
		logic [3:0] idx;
		logic [15:0] pc_hold;
		logic [1:0] ist;
		logic [1:0] imsk;
		logic [7:0] rdata;
		logic irq;
		mia_seq_out_t so;
	} mia_regs_t;

endpackage : mia_pkg

// *** hw/mia_prio_enc.sv ***
// Fixed priority encoder: lowest set index wins.
// Assumes a purely combinational use inside a clocked owner.
`timescale 1ns/10ps
module mia_prio_enc
	import mia_pkg::*;
#(
	parameter int W = 16
) (
	input wire logic [W-1:0] vec, // Candidate requests
	output logic [$clog2(W)-1:0] idx, // Winning index
	output logic valid // Any candidate set
);

	always_comb begin
		idx = '0;
		valid = 1'b0;
		// Scan from the top so the lowest index is left standing
		for (int i = W - 1; i >= 0; i--) begin
			if (vec[i]) begin
				idx = i[$clog2(W)-1:0];
				valid = 1'b1;
			end
		end
	end

endmodule : mia_prio_enc

// *** hw/mia_top.sv ***
// Maskable interrupt acknowledge logic beside an 8-bit CPU sequencer.
// Assumes the sequencer marks each instruction's next-to-last and last
// clocks, stalls while busy is high, and fetches from the vector address.
//
// Operation
// - Status word holds global enable; set by writes or enable/disable.
// - Reset loads status word with 02H, global enable cleared.
// - Serve flag set, mask clear; vectoring also needs the enable.
// - Acknowledge pushes status word then PC, clears enable, loads vector.
// - Request to service start takes 9 to 19 CPU clocks.
// - Simultaneous requests served in fixed priority, highest first.
// - Unacknowledgeable request stays pending, served once conditions allow.
// - Flag set before next-to-last clock: serve after this instruction.
// - Flag set in last clock: one more instruction runs first.
// - Requests held pending during any flag or mask register access.
// - After flag or mask access, serving waits one more instruction.
// - Nesting only when the routine re-enables; else request waits.
// - Request flag set by source, cleared on acknowledge or reset.
// - Mask bit 1 blocks, 0 permits; reset sets all masks.
//
// Our own choices: the register offsets and the strobed register port.
`timescale 1ns/10ps
`include "mia_consts.svh"
module mia_top
	import mia_pkg::*;
(
	input wire logic core_clk, // CPU clock
	input wire logic rst, // Async reset, high
	input wire mia_bus_req_t bus, // Register port request
	output logic [7:0] bus_rdata, // Read data, cycle after strobe
	input wire mia_seq_in_t seq, // Sequencer handshakes
	input wire logic [15:0] src_req, // Source request pulses
	output mia_seq_out_t seq_out, // Stack and PC control
	output logic [7:0] psw_out, // Program status word
	output logic irq // Event interrupt level
);

	// ****************************************
	// State
	// ****************************************
	mia_regs_t r;
	mia_regs_t r_nxt;
	logic [15:0] elig;
	logic [15:0] cand;
	logic [3:0] win_idx;
	logic win_valid;
	logic if_mk_acc;
	logic go;

	assign bus_rdata = r.rdata;
	assign seq_out = r.so;
	assign psw_out = r.program_status_word;
	assign irq = r.irq;

	// ****************************************
	// Selection
	// ****************************************
	assign elig = r.req & ~r.msk;
	assign cand = r.snap & elig;

	mia_prio_enc #(
		.W(16)
	) u_prio (
		.vec(cand),
		.idx(win_idx),
		.valid(win_valid)
	);

	assign if_mk_acc = (bus.wr || bus.rd) &&
		(bus.addr == `MIA_A_REQ_LO || bus.addr == `MIA_A_REQ_HI ||
		bus.addr == `MIA_A_MSK_LO || bus.addr == `MIA_A_MSK_HI);

	// Only at an instruction boundary, never over a pending defer
	assign go = (r.st == MIA_ST_IDLE) && seq.instr_done && win_valid &&
		r.program_status_word[`MIA_GEN_BIT] &&
		!r.acc_seen && !if_mk_acc;

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		logic [15:0] req_clr;
		logic [15:0] wmask;
		logic [1:0] ev;
		req_clr = `MIA_ZERO16;
		wmask = `MIA_ZERO16;
		ev = 2'b00;
		r_nxt = r;
		r_nxt.so.stk_push = 1'b0;
		r_nxt.so.pc_load = 1'b0;
		r_nxt.rdata = `MIA_ZERO8;

		// Snapshot at the next-to-last clock; a later flag misses it
		if (seq.instr_penult) begin
			r_nxt.snap = if_mk_acc ? `MIA_ZERO16 : elig;
		end
		if (seq.instr_done) begin
			r_nxt.acc_seen = 1'b0;
		end
		if (if_mk_acc) begin
			r_nxt.acc_seen = 1'b1;
		end

		// Register port writes
		if (bus.wr) begin
			case (bus.addr)
				`MIA_A_REQ_LO: begin
					r_nxt.req[7:0] = bus.wdata;
				end
				`MIA_A_REQ_HI: begin
					r_nxt.req[15:8] = bus.wdata;
				end
				`MIA_A_MSK_LO: begin
					r_nxt.msk[7:0] = bus.wdata;
				end
				`MIA_A_MSK_HI: begin
					r_nxt.msk[15:8] = bus.wdata;
				end
				`MIA_A_PSW: begin
					r_nxt.program_status_word = bus.wdata;
				end
				`MIA_A_IST: begin
					r_nxt.ist = r.ist & ~bus.wdata[1:0];
				end
				`MIA_A_IMSK: begin
					r_nxt.imsk = bus.wdata[1:0];
				end
				default: begin
					r_nxt.imsk = r.imsk;
				end
			endcase
		end

		// Register port reads, unmapped reads zero
		if (bus.rd) begin
			case (bus.addr)
				`MIA_A_REQ_LO: begin
					r_nxt.rdata = r.req[7:0];
				end
				`MIA_A_REQ_HI: begin
					r_nxt.rdata = r.req[15:8];
				end
				`MIA_A_MSK_LO: begin
					r_nxt.rdata = r.msk[7:0];
				end
				`MIA_A_MSK_HI: begin
					r_nxt.rdata = r.msk[15:8];
				end
				`MIA_A_PSW: begin
					r_nxt.rdata = r.program_status_word;
				end
				`MIA_A_IST: begin
					r_nxt.rdata = {6'h00, r.ist};
				end
				`MIA_A_IMSK: begin
					r_nxt.rdata = {6'h00, r.imsk};
				end
				default: begin
					r_nxt.rdata = `MIA_ZERO8;
				end
			endcase
		end

		// Enable and disable instructions override a byte write
		if (seq.dis_ins) begin
			r_nxt.program_status_word[`MIA_GEN_BIT] = 1'b0;
		end
		if (seq.en_ins) begin
			r_nxt.program_status_word[`MIA_GEN_BIT] = 1'b1;
		end
		// Sequencer pops the PC, then hands us the popped status word
		if (seq.ret_ins) begin
			r_nxt.program_status_word = seq.ret_word;
			ev[`MIA_EV_RET] = 1'b1;
		end

		// Acknowledge sequence
		case (r.st)
			MIA_ST_IDLE: begin
				if (go) begin
					r_nxt.so.stk_push = 1'b1;
					r_nxt.so.stk_data = r.program_status_word;
					r_nxt.program_status_word[`MIA_GEN_BIT] = 1'b0;
					r_nxt.idx = win_idx;
					r_nxt.pc_hold = seq.pc;
					r_nxt.so.busy = 1'b1;
					req_clr[win_idx] = 1'b1;
					ev[`MIA_EV_ACK] = 1'b1;
					r_nxt.snap = `MIA_ZERO16;
					r_nxt.st = MIA_ST_PCH;
				end
			end
			MIA_ST_PCH: begin
				r_nxt.so.stk_push = 1'b1;
				r_nxt.so.stk_data = r.pc_hold[15:8];
				r_nxt.st = MIA_ST_PCL;
			end
			MIA_ST_PCL: begin
				r_nxt.so.stk_push = 1'b1;
				r_nxt.so.stk_data = r.pc_hold[7:0];
				r_nxt.st = MIA_ST_VEC;
			end
			MIA_ST_VEC: begin
				r_nxt.so.pc_load = 1'b1;
				r_nxt.so.pc_vec = `MIA_VEC_BASE + {11'h000, r.idx, 1'b0};
				r_nxt.so.busy = 1'b0;
				r_nxt.st = MIA_ST_IDLE;
			end
			default: begin
				r_nxt.st = MIA_ST_IDLE;
			end
		endcase

		// A new request outlives a same-cycle clear or write of zero
		r_nxt.req = (r_nxt.req & ~req_clr) | src_req;
		wmask = `MIA_UNUSED_BITS;
		r_nxt.req = r_nxt.req & ~wmask;
		r_nxt.msk = r_nxt.msk | wmask;

		// Sticky events, set wins over write-one-to-clear
		r_nxt.ist = r_nxt.ist | ev;
		r_nxt.irq = |(r_nxt.ist & r_nxt.imsk);
	end

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			r.st <= MIA_ST_IDLE;
			r.req <= `MIA_REQ_RST;
			r.msk <= `MIA_MSK_RST;
			r.program_status_word <= `MIA_PSW_RST;
			r.snap <= `MIA_ZERO16;
			r.acc_seen <= 1'b0;
			r.idx <= 4'h0;
			r.pc_hold <= `MIA_ZERO16;
			r.ist <= `MIA_IST_RST;
			r.imsk <= `MIA_IMSK_RST;
			r.rdata <= `MIA_ZERO8;
			r.irq <= 1'b0;
			r.so.busy <= 1'b0;
			r.so.stk_push <= 1'b0;
			r.so.stk_data <= `MIA_ZERO8;
			r.so.pc_load <= 1'b0;
			r.so.pc_vec <= `MIA_ZERO16;
		end else begin
			r <= r_nxt;
		end
	end

endmodule : mia_top

// *** dv/mia_seq_mdl.sv ***
// Sequencer stand-in: four-clock instructions, stack capture.
// Assumes bench pulses ctl (enable, disable, return) one clock.
`timescale 1ns/10ps
module mia_seq_mdl
	import mia_pkg::*;
(
	input wire logic core_clk, // CPU clock
	input wire logic rst, // Async reset, high
	input wire logic busy, // Stall request
	input wire logic push, // Stack push strobe
	input wire logic [7:0] data, // Pushed byte
	input wire logic [2:0] ctl, // Enable, disable, return
	output mia_seq_in_t seq // Sequencer handshakes
);
	logic [1:0] cnt_r;
	logic b_r;
	logic [7:0] stk_r;
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cnt_r <= 2'h0;
			b_r <= 1'b0;
			stk_r <= 8'h00;
		end else begin
			b_r <= busy;
			if (!busy)
				cnt_r <= cnt_r + 2'h1;
			if (push && !b_r)
				stk_r <= data;
		end
	end
	// Frozen while stacking; return hands back the stacked word
	assign seq = '{cnt_r == 2'h2 && !busy, cnt_r == 2'h3 && !busy,
		ctl[2], ctl[1], ctl[0], stk_r, 16'h1234};
endmodule : mia_seq_mdl

// *** dv/mia_assertions.sv ***
// Checker on the acknowledge block's ports.
// Assumes one clock domain; bound to mia_top below.
`timescale 1ns/10ps
`include "mia_consts.svh"
module mia_assertions
	import mia_pkg::*;
(
	input wire logic core_clk, // CPU clock
	input wire logic rst, // Async reset, high
	input wire mia_bus_req_t bus, // Register port request
	input wire logic [7:0] bus_rdata, // Read data
	input wire mia_seq_in_t seq, // Sequencer handshakes
	input wire logic [15:0] src_req, // Source requests
	input wire mia_seq_out_t seq_out, // Stack and PC control
	input wire logic [7:0] psw_out, // Status word
	input wire logic irq // Event interrupt
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	ack_start_a: assert property (
		$rose(seq_out.busy) |-> seq_out.stk_push && !psw_out[`MIA_GEN_BIT])
		else $error("ack start wrong");
	push_seq_a: assert property (
		$rose(seq_out.busy) |-> seq_out.stk_push[*3]
		##1 (seq_out.pc_load && !seq_out.busy)) else $error("ack order");
	ack_cause_a: assert property (
		$rose(seq_out.busy) |-> $past(seq.instr_done)
		&& $past(psw_out[`MIA_GEN_BIT])) else $error("ack no cause");
	no_ack_a: assert property (
		seq.instr_done && !psw_out[`MIA_GEN_BIT] |=> !seq_out.stk_push)
		else $error("ack while off");
	rd_idle_a: assert property (
		!bus.rd |=> bus_rdata == 8'h00) else $error("rdata idle");
	en_set_a: assert property (
		seq.en_ins && !seq.ret_ins && !seq.instr_done |=>
		psw_out[`MIA_GEN_BIT]) else $error("enable lost");
	dis_clr_a: assert property (
		seq.dis_ins && !seq.en_ins && !seq.ret_ins |=>
		!psw_out[`MIA_GEN_BIT]) else $error("disable lost");
	ret_ld_a: assert property (
		seq.ret_ins && !seq.instr_done |=> psw_out == $past(seq.ret_word))
		else $error("return word");
endmodule : mia_assertions
bind mia_top mia_assertions u_chk(.core_clk(core_clk), .rst(rst),
	.bus(bus), .bus_rdata(bus_rdata), .seq(seq), .src_req(src_req),
	.seq_out(seq_out), .psw_out(psw_out), .irq(irq));

// *** dv/tb_top.sv ***
// Bench: register port, sources and sequencer pulses.
// Assumes mia_seq_mdl in the sequencer's place.
`timescale 1ns/10ps
`include "mia_consts.svh"
module tb_top
	import mia_pkg::*;
;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	mia_bus_req_t bus = '0;
	logic [7:0] bus_rdata, psw_out;
	logic [15:0] src_req = '0;
	logic [2:0] ctl = '0;
	logic irq;
	mia_seq_in_t seq;
	mia_seq_out_t so;
	int error_cnt = 0;
	int checked = 0;
	always #4 core_clk = ~core_clk;
	mia_top DUT(.core_clk(core_clk), .rst(rst), .bus(bus),
		.bus_rdata(bus_rdata), .seq(seq), .src_req(src_req),
		.seq_out(so), .psw_out(psw_out), .irq(irq));
	mia_seq_mdl SEQ(.core_clk(core_clk), .rst(rst), .busy(so.busy),
		.push(so.stk_push), .data(so.stk_data), .ctl(ctl), .seq(seq));
	// ****
	// Drivers; each starts and ends just after a rising edge
	// ****
	task automatic chk(string n, logic [15:0] e, logic [15:0] g);
		checked++;
		if (g !== e) begin
			error_cnt++;
			$display("[ERR] %s exp %h got %h", n, e, g);
		end
	endtask : chk
	task automatic cyc(int n);
		repeat (n) @(posedge core_clk);
	endtask : cyc
	task automatic wr(logic [7:0] a, logic [7:0] d);
		bus <= '{a, d, 1'b1, 1'b0};
		@(posedge core_clk);
		bus <= '0;
		@(posedge core_clk);
	endtask : wr
	task automatic rd(logic [7:0] a, logic [7:0] e);
		bus <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge core_clk);
		bus <= '0;
		@(negedge core_clk);
		chk("rdata", {8'h00, e}, {8'h00, bus_rdata});
		@(posedge core_clk);
	endtask : rd
	task automatic src(logic [15:0] v);
		src_req <= v;
		@(posedge core_clk);
		src_req <= '0;
		@(posedge core_clk);
	endtask : src
	task automatic pulse(logic [2:0] c);
		ctl <= c;
		@(posedge core_clk);
		ctl <= '0;
		@(posedge core_clk);
	endtask : pulse
	task automatic ack(logic [7:0] p, logic [15:0] v);
		int i;
		@(negedge core_clk);
		for (i = 0; i < 60 && so.stk_push !== 1'b1; i++)
			@(negedge core_clk);
		chk("psw", {8'h00, p}, {8'h00, so.stk_data});
		chk("gen", 16'h0000, {15'h0, psw_out[`MIA_GEN_BIT]});
		@(negedge core_clk);
		chk("pch", 16'h0012, {8'h00, so.stk_data});
		@(negedge core_clk);
		chk("pcl", 16'h0034, {8'h00, so.stk_data});
		@(negedge core_clk);
		chk("vec", v, so.pc_vec);
		chk("load", 16'h0001, {15'h0, so.pc_load});
		@(posedge core_clk);
	endtask : ack
	// ****
	// Scenarios
	// ****
	task automatic t_rst();
		chk("psw", 16'h0002, {8'h00, psw_out});
		rd(`MIA_A_REQ_HI, 8'h00);
		rd(`MIA_A_MSK_LO, 8'hFF);
		rd(`MIA_A_MSK_HI, 8'hFF);
		rd(8'h20, 8'h00);
		wr(`MIA_A_PSW, 8'h82);
		chk("psw", 16'h0082, {8'h00, psw_out});
		pulse(3'b010);
		chk("psw", 16'h0002, {8'h00, psw_out});
	endtask : t_rst
	task automatic t_pend();
		wr(`MIA_A_IMSK, 8'h01);
		src(16'h0002);
		wr(`MIA_A_PSW, 8'h82);
		cyc(30);
		rd(`MIA_A_REQ_LO, 8'h02);
		wr(`MIA_A_MSK_LO, 8'h00);
		ack(8'h82, 16'h0006);
		rd(`MIA_A_REQ_LO, 8'h00);
		chk("irq", 16'h0001, {15'h0, irq});
		wr(`MIA_A_IST, 8'h01);
		cyc(1);
		chk("irq", 16'h0000, {15'h0, irq});
	endtask : t_pend
	task automatic t_prio();
		src(16'h000C);
		pulse(3'b100);
		ack(8'h82, 16'h0008);
		cyc(30);
		rd(`MIA_A_REQ_LO, 8'h08);
		wr(`MIA_A_IST, 8'h03);
		wr(`MIA_A_IMSK, 8'h02);
		rd(`MIA_A_IMSK, 8'h02);
		pulse(3'b001);
		chk("irq", 16'h0001, {15'h0, irq});
		ack(8'h82, 16'h000A);
		rd(`MIA_A_IST, 8'h03);
	endtask : t_prio
	task automatic t_late();
		int i;
		for (i = 0; i < 2; i++) begin
			wr(`MIA_A_PSW, 8'h82);
			@(negedge core_clk);
			while (seq.instr_done !== 1'b1)
				@(negedge core_clk);
			// Flag lands before the next-to-last clock, then in the next-to-last one
			repeat (i + 2) @(posedge core_clk);
			src_req <= 16'h0010;
			@(posedge core_clk);
			src_req <= '0;
			repeat (2 + 3 * i) @(posedge core_clk);
			@(negedge core_clk);
			chk("lat", 16'h0182, {7'h00, so.stk_push, so.stk_data});
			repeat (3) @(negedge core_clk);
			chk("vec", 16'h000C, so.pc_vec);
			@(posedge core_clk);
		end
	endtask : t_late
	task automatic finish_test();
		if (error_cnt == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : finish_test
	initial begin
		repeat (6) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		t_rst();
		t_pend();
		t_prio();
		t_late();
		finish_test();
	end
	initial begin
		#100000;
		error_cnt++;
		finish_test();
	end
endmodule : tb_top
